/* bench/spp_host.sv */
`default_nettype none
module spp_host (
   output logic      sck_out,
   output logic      cs_b_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sck_out = 1'b0;
      cs_b_out = 1'b1;
      mosi_out = 1'b0;
   end
   // clock parked low outside frames; data moves on the falling edge
   task automatic xfer(input logic [71:0] d, input int n, output logic [63:0] rd);
      rd = '0;
      cs_b_out <= 1'b0;
      #32;
      for (int i = n - 1; i >= 0; i--) begin
         mosi_out <= d[i];
         #32;
         sck_out <= 1'b1;
         #32;
         // sample late: the device answer trails the fall by a few clocks
         rd = {rd[62:0], miso_in};
         sck_out <= 1'b0;
      end
      #32;
      cs_b_out <= 1'b1;
      // released line shows the opposite level so a stale bit never looks valid
      mosi_out <= ~mosi_out;
      #100;
   endtask
endmodule
`default_nettype wire

/* bench/spp_top_asserts.sv */
`default_nettype none
module spp_top_asserts (
   input wire logic       clk_in,
   input wire logic       rst_b_in,
   input wire logic       factory_b_in,
   input wire logic       sck_in,
   input wire logic       cs_b_in,
   input wire logic       mosi_in,
   input wire logic       miso_out,
   input wire logic       miso_oe_out,
   input wire logic [7:0] chk_addr_in,
   input wire logic       chk_block_out,
   input wire logic       freeze_out,
   input wire logic       pwd_en_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   ////////////////////////////////////////////////////////////////////////////////
   chk_oe_drop: assert property (cs_b_in [*8] |-> !miso_oe_out)
      else $error("read driver still on after deselect");
   chk_reset_quiet: assert property ($rose(rst_b_in) |-> !chk_block_out && !pwd_en_out)
      else $error("outputs not cleared by reset");
   chk_frz_boot: assert property ($rose(rst_b_in) ##1 pwd_en_out |-> !freeze_out)
      else $error("freeze not locked after reset");
   // the edge after release still shows reset values, so skip it
   chk_frz_rise: assert property ($rose(freeze_out) && $past(rst_b_in, 2)
      |-> cs_b_in && pwd_en_out)
      else $error("freeze released without password frame");
   chk_frz_fall: assert property ($fell(freeze_out) && $past(rst_b_in, 2) |-> cs_b_in)
      else $error("freeze set inside a frame");
   chk_frz_steady: assert property (!cs_b_in [*6] |-> $stable(freeze_out))
      else $error("freeze moved mid frame");
   chk_pwd_sticky: assert property (pwd_en_out |=> pwd_en_out)
      else $error("password mode dropped");
   chk_pwd_rise: assert property ($rose(pwd_en_out) && $past(rst_b_in, 2)
      |-> cs_b_in && $past(cs_b_in))
      else $error("password mode set inside a frame");
   // select pin passes four flops before the driver sees it
   chk_oe_frame: assert property (miso_oe_out |-> !$past(cs_b_in, 4))
      else $error("read driver on outside a frame");
   cov_unlock: cover property ($rose(freeze_out));
   cov_freeze: cover property ($fell(freeze_out));
   cov_pwd: cover property ($rose(pwd_en_out));
   cov_block: cover property ($rose(chk_block_out));
   cov_read: cover property ($rose(miso_oe_out));
endmodule
bind spp_top spp_top_asserts u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .factory_b_in(factory_b_in), .sck_in(sck_in), .cs_b_in(cs_b_in), .mosi_in(mosi_in),
   .miso_out(miso_out), .miso_oe_out(miso_oe_out), .chk_addr_in(chk_addr_in),
   .chk_block_out(chk_block_out), .freeze_out(freeze_out), .pwd_en_out(pwd_en_out));
`default_nettype wire

/* bench/spp_top_test.sv */
`default_nettype none
module spp_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [63:0] PW = 64'h0123_4567_89AB_CDEF;
   logic        clk;
   logic        rst_b;
   logic        fac_b;
   logic        sck;
   logic        cs_b;
   logic        mosi;
   logic        miso;
   logic        blk;
   logic        frz;
   logic        pwd;
   logic [7:0]  addr;
   logic [63:0] rd;
   int          n_errors;
   int          tests_run;
   always #2.5 clk = ~clk;
   spp_host host (.sck_out(sck), .cs_b_out(cs_b), .mosi_out(mosi), .miso_in(miso));
   spp_top DUT (.clk_in(clk), .rst_b_in(rst_b), .factory_b_in(fac_b), .sck_in(sck),
      .cs_b_in(cs_b), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(), .chk_addr_in(addr),
      .chk_block_out(blk), .freeze_out(frz), .pwd_en_out(pwd));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task cmd(input logic [71:0] d, input int n);
      host.xfer(d, n, rd);
   endtask
   task blk_is(input logic [7:0] a, input logic e);
      @(posedge clk);
      addr <= a;
      repeat (3) @(posedge clk);
      chk({63'h0, blk}, {63'h0, e});
   endtask
   task do_reset(input logic fac);
      @(posedge clk);
      rst_b <= 1'b0;
      fac_b <= ~fac;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      fac_b <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   task conclude;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_factory;
      do_reset(1'b1);
      cmd({8'h2D, 16'h0000}, 24);
      chk(rd[15:0], 16'hFFFF);
      cmd({8'hA7, 8'h00}, 16);
      chk(rd[7:0], 8'h01);
      cmd({8'hE2, 8'h50, 8'h00}, 24);
      chk(rd[0], 1'b1);
      blk_is(8'h35, 1'b0);
      chk(pwd, 1'b0);
   endtask
   task t_vlock;
      cmd({8'hE5, 8'h10, 8'h01}, 24);
      blk_is(8'h10, 1'b1);
      cmd({8'hE5, 8'h03, 8'h01}, 24);
      blk_is(8'h03, 1'b1);
      blk_is(8'h04, 1'b0);
      cmd({8'hE8, 8'h03, 8'h00}, 24);
      chk(rd[0], 1'b1);
   endtask
   task t_nv_freeze;
      // lock pattern goes in before the freeze
      cmd({8'hE3, 8'h20}, 16);
      blk_is(8'h25, 1'b1);
      cmd({8'hE2, 8'h20, 8'h00}, 24);
      chk(rd[0], 1'b0);
      cmd(8'hA6, 8);
      chk(frz, 1'b0);
      cmd({8'hA7, 8'h00}, 16);
      chk(rd[7:0], 8'h00);
      cmd(8'hE4, 8);
      blk_is(8'h25, 1'b1);
      cmd({8'hE3, 8'h40}, 16);
      blk_is(8'h40, 1'b0);
   endtask
   task t_reset_keep;
      do_reset(1'b0);
      blk_is(8'h10, 1'b0);
      blk_is(8'h25, 1'b1);
      chk(frz, 1'b1);
      // a write-freeze frame of the wrong length must change nothing
      cmd({8'hA6, 8'h00}, 16);
      chk(frz, 1'b1);
      cmd(8'hE4, 8);
      blk_is(8'h25, 1'b0);
      cmd({8'h2C, 16'hFFF9}, 24);
      cmd({8'h2D, 16'h0000}, 24);
      chk(rd[15:0], 16'hFFFF);
   endtask
   task t_password;
      cmd({8'h28, PW}, 72);
      cmd({8'h27, 64'h0}, 72);
      chk(rd, PW);
      cmd({8'h2C, 16'h0003}, 24);
      chk(pwd, 1'b1);
      cmd({8'h2D, 16'h0000}, 24);
      chk(rd[15:0], 16'hFFFB);
      cmd({8'h27, 64'h0}, 72);
      chk(rd, 64'hFFFF_FFFF_FFFF_FFFF);
      cmd({8'h28, ~PW}, 72);
      cmd({8'h2C, 16'hFFFD}, 24);
      cmd({8'h2D, 16'h0000}, 24);
      chk(rd[15:0], 16'hFFFB);
   endtask
   task t_unlock;
      cmd(8'hA6, 8);
      cmd({8'h29, PW ^ 64'h1}, 72);
      chk(frz, 1'b0);
      cmd({8'h29, PW ^ 64'h8000_0000_0000_0000}, 72);
      chk(frz, 1'b0);
      cmd({8'h29, PW}, 72);
      chk(frz, 1'b1);
      do_reset(1'b0);
      chk(frz, 1'b0);
      cmd({8'h29, PW}, 72);
      chk(frz, 1'b1);
   endtask
   task t_prot_only;
      do_reset(1'b1);
      cmd({8'h2C, 16'hFFFD}, 24);
      cmd({8'h2C, 16'hFFF9}, 24);
      chk(pwd, 1'b0);
      cmd({8'h2D, 16'h0000}, 24);
      chk(rd[15:0], 16'hFFFD);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      fac_b = 1'b1;
      addr = 8'h00;
      n_errors = 0;
      tests_run = 0;
      t_factory;
      t_vlock;
      t_nv_freeze;
      t_reset_keep;
      t_password;
      t_unlock;
      t_prot_only;
      conclude;
   end
   // about thirty frames of at most five microseconds each
   initial begin
      #400us;
      n_errors++;
      conclude;
   end
endmodule
`default_nettype wire

/* design/spp_params.svh */
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

// array geometry
`define SPP_SEC_N      16
`define SPP_SUB_N      16
`define SPP_SEC_W      4
`define SPP_ADDR_W     8
`define SPP_FIRST_SEC  4'h0
`define SPP_LAST_SEC   4'hF

// register widths and bit positions
`define SPP_PWD_W      64
`define SPP_MODE_W     16
`define SPP_FRZ_W      8
`define SPP_OPC_W      8
`define SPP_CNT_W      7
`define SPP_MODE_PWD   2
`define SPP_MODE_PROT  1
`define SPP_VDATA_BIT  0
// address byte of a volatile write sits just above its data byte
`define SPP_WV_ADDR_LO 8

// reset and factory values
`define SPP_PWD_BLANK  64'hFFFF_FFFF_FFFF_FFFF
`define SPP_RSV_HI     13'h1FFF
`define SPP_PINS_IDLE  3'h2

// frame lengths in link clocks, opcode included
`define SPP_LEN_OPC    7'h08
`define SPP_LEN_ADDR   7'h10
`define SPP_LEN_MODE   7'h18
`define SPP_LEN_VLOCK  7'h18
`define SPP_LEN_PWD    7'h48
`define SPP_CNT_MAX    7'h7F

// command opcodes
`define SPP_OP_RD_MODE 8'h2D
`define SPP_OP_WR_MODE 8'h2C
`define SPP_OP_RD_PWD  8'h27
`define SPP_OP_WR_PWD  8'h28
`define SPP_OP_UNLOCK  8'h29
`define SPP_OP_RD_FRZ  8'hA7
`define SPP_OP_WR_FRZ  8'hA6
`define SPP_OP_RD_NV   8'hE2
`define SPP_OP_WR_NV   8'hE3
`define SPP_OP_ERS_NV  8'hE4
`define SPP_OP_RD_V    8'hE8
`define SPP_OP_WR_V    8'hE5

`endif

/* design/spp_pkg.sv */
`default_nettype none
package spp_pkg;

   typedef struct packed {
      logic sck;
      logic cs_b;
      logic mosi;
   } spp_pins_t;

   typedef struct packed {
      logic [12:0] rsv_hi;
      logic        pwd_dis;
      logic        prot_sel;
      logic        rsv_lo;
   } spp_mode_t;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_OPC    = 4'b0010,
      ST_ARG    = 4'b0100,
      ST_IGNORE = 4'b1000
   } spp_state_t;

endpackage
`default_nettype wire

/* design/spp_sync.sv */
`default_nettype none
module spp_sync #(
   parameter int unsigned      W   = 1,
   parameter logic [W-1:0]     RST = '0
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // a change is taken only once two later stages agree
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         s1    <= RST;
         s2    <= RST;
         s3    <= RST;
         q_out <= RST;
      end else begin
         s1 <= d_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q_out <= s3;
         end
      end
   end

endmodule
`default_nettype wire

/* design/spp_top.sv */
// Notes on behaviour
// - 16-bit mode register, only bits 2:1 act
// - volatile freeze bit guards all nonvolatile locks
// - one nonvolatile lock per sector, kept
// - one volatile lock per sector, cleared by reset
// - first/last sector: volatile lock per subsector
// - bit 2 cleared makes password permanent, hidden
// - bit 1 cleared keeps bit 2 at one
// - bits 2:1 one-time, never both zero
// - password set before bit 2; then frozen
// - password enabled: freeze released only by match
// - wrong password leaves freeze unchanged
// - factory state: every sector unlocked
// - freeze register 8 bits, bits 7:1 zero
// - freeze zero: nonvolatile lock writes ignored
// - read-freeze command returns freeze bit
// - password enabled: reset forces freeze locked
// - password enabled: correct unlock command sets freeze to one
// - write-freeze command clears freeze to zero
// - nonvolatile lock zero blocks its sector
// - volatile lock one blocks its sector
`default_nettype none
`include "spp_params.svh"
module spp_top (
   input  wire logic                   clk_in,
   input  wire logic                   rst_b_in,
   input  wire logic                   factory_b_in,
   input  wire logic                   sck_in,
   input  wire logic                   cs_b_in,
   input  wire logic                   mosi_in,
   output logic                        miso_out,
   output logic                        miso_oe_out,
   input  wire logic [`SPP_ADDR_W-1:0] chk_addr_in,
   output logic                        chk_block_out,
   output logic                        freeze_out,
   output logic                        pwd_en_out
);

   ////////////////////////////////////////////////////////////////////////////
   // link sampling

   localparam int unsigned PW = $bits(spp_pkg::spp_pins_t);

   spp_pkg::spp_pins_t            raw_pins;
   spp_pkg::spp_pins_t            pins;
   logic [PW-1:0]                 pins_bits;
   logic                          sck_q;
   logic                          rise;
   logic                          fall;

   assign raw_pins = '{sck: sck_in, cs_b: cs_b_in, mosi: mosi_in};

   spp_sync #(
      .W   (PW),
      .RST (`SPP_PINS_IDLE)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .d_in     (raw_pins),
      .q_out    (pins_bits)
   );

   assign pins = spp_pkg::spp_pins_t'(pins_bits);
   assign rise = pins.sck & ~sck_q & ~pins.cs_b;
   assign fall = ~pins.sck & sck_q & ~pins.cs_b;

   ////////////////////////////////////////////////////////////////////////////
   // state

   spp_pkg::spp_state_t           state;
   logic [`SPP_CNT_W-1:0]         bit_cnt;
   logic [`SPP_PWD_W-1:0]         rx;
   logic [`SPP_OPC_W-1:0]         opc;
   logic [`SPP_PWD_W-1:0]         tx;
   logic                          tx_act;

   // nonvolatile cells: kept over rst_b_in, loaded with factory values by factory_b_in
   logic                          pwd_dis;
   logic                          prot_sel;
   logic [`SPP_PWD_W-1:0]         pwd;
   logic [`SPP_SEC_N-1:0]         nv_lock;

   // volatile cells
   logic                          freeze;
   logic [`SPP_SEC_N-1:0]         v_lock;
   logic [`SPP_SUB_N-1:0]         v_sub_first;
   logic [`SPP_SUB_N-1:0]         v_sub_last;

   ////////////////////////////////////////////////////////////////////////////
   // decode

   logic [`SPP_OPC_W-1:0]         next_byte;
   logic                          done;
   logic [`SPP_SEC_W-1:0]         wr_sec;
   logic [`SPP_SEC_W-1:0]         wr_sub;
   logic [`SPP_SEC_W-1:0]         nv_sec;
   spp_pkg::spp_mode_t            mode_rd;
   logic                          next_pwd_dis;
   logic                          next_prot_sel;
   logic                          do_wr_mode;
   logic                          do_wr_pwd;
   logic                          do_unlock;
   logic                          do_wr_frz;
   logic                          do_wr_nv;
   logic                          do_ers_nv;
   logic                          do_wr_v;
   logic                          pwd_match;

   assign next_byte = {rx[`SPP_OPC_W-2:0], pins.mosi};
   // a write frame acts only when chip select rises after the exact length
   assign done      = pins.cs_b & (state == spp_pkg::ST_ARG);
   assign wr_sec    = rx[`SPP_WV_ADDR_LO+`SPP_ADDR_W-1 : `SPP_WV_ADDR_LO+`SPP_SEC_W];
   assign wr_sub    = rx[`SPP_WV_ADDR_LO+`SPP_SEC_W-1 : `SPP_WV_ADDR_LO];
   // a lock write ends on its address byte, so the sector sits in rx bits 7:4
   assign nv_sec    = rx[`SPP_ADDR_W-1:`SPP_SEC_W];

   assign mode_rd = '{rsv_hi: `SPP_RSV_HI, pwd_dis: pwd_dis,
                      prot_sel: prot_sel, rsv_lo: 1'b1};

   // bits only ever go from one to zero
   assign next_pwd_dis  = pwd_dis & rx[`SPP_MODE_PWD];
   assign next_prot_sel = prot_sel & rx[`SPP_MODE_PROT];
   assign pwd_match     = (rx == pwd);

   assign do_wr_mode = done & (opc == `SPP_OP_WR_MODE) & (bit_cnt == `SPP_LEN_MODE);
   assign do_wr_pwd  = done & (opc == `SPP_OP_WR_PWD) & (bit_cnt == `SPP_LEN_PWD);
   assign do_unlock  = done & (opc == `SPP_OP_UNLOCK) & (bit_cnt == `SPP_LEN_PWD);
   assign do_wr_frz  = done & (opc == `SPP_OP_WR_FRZ) & (bit_cnt == `SPP_LEN_OPC);
   assign do_wr_nv   = done & (opc == `SPP_OP_WR_NV) & (bit_cnt == `SPP_LEN_ADDR);
   assign do_ers_nv  = done & (opc == `SPP_OP_ERS_NV) & (bit_cnt == `SPP_LEN_OPC);
   assign do_wr_v    = done & (opc == `SPP_OP_WR_V) & (bit_cnt == `SPP_LEN_VLOCK);

   function automatic logic known(input logic [`SPP_OPC_W-1:0] op);
      case (op)
         `SPP_OP_RD_MODE, `SPP_OP_WR_MODE, `SPP_OP_RD_PWD, `SPP_OP_WR_PWD,
         `SPP_OP_UNLOCK, `SPP_OP_RD_FRZ, `SPP_OP_WR_FRZ, `SPP_OP_RD_NV,
         `SPP_OP_WR_NV, `SPP_OP_ERS_NV, `SPP_OP_RD_V, `SPP_OP_WR_V: known = 1'b1;
         default: known = 1'b0;
      endcase
   endfunction

   // volatile lock seen at one address, subsector grain at both ends
   function automatic logic v_bit(input logic [`SPP_ADDR_W-1:0] a);
      logic [`SPP_SEC_W-1:0] s;
      s = a[`SPP_ADDR_W-1:`SPP_SEC_W];
      if (s == `SPP_FIRST_SEC) begin
         v_bit = v_sub_first[a[`SPP_SEC_W-1:0]];
      end else if (s == `SPP_LAST_SEC) begin
         v_bit = v_sub_last[a[`SPP_SEC_W-1:0]];
      end else begin
         v_bit = v_lock[s];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // framing

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         sck_q   <= 1'b0;
         state   <= spp_pkg::ST_IDLE;
         bit_cnt <= '0;
         rx      <= '0;
         opc     <= '0;
      end else begin
         sck_q <= pins.sck;
         case (state)
            spp_pkg::ST_IDLE: begin
               bit_cnt <= '0;
               if (!pins.cs_b) begin
                  state <= spp_pkg::ST_OPC;
               end
            end
            spp_pkg::ST_OPC: begin
               if (pins.cs_b) begin
                  state <= spp_pkg::ST_IDLE;
               end else if (rise) begin
                  rx      <= {rx[`SPP_PWD_W-2:0], pins.mosi};
                  bit_cnt <= bit_cnt + 1'b1;
                  if (bit_cnt == `SPP_LEN_OPC - 1'b1) begin
                     opc   <= next_byte;
                     state <= known(next_byte) ? spp_pkg::ST_ARG : spp_pkg::ST_IGNORE;
                  end
               end
            end
            spp_pkg::ST_ARG, spp_pkg::ST_IGNORE: begin
               if (pins.cs_b) begin
                  state <= spp_pkg::ST_IDLE;
               end else if (rise) begin
                  rx <= {rx[`SPP_PWD_W-2:0], pins.mosi};
                  if (bit_cnt != `SPP_CNT_MAX) begin
                     bit_cnt <= bit_cnt + 1'b1;
                  end
               end
            end
            default: state <= spp_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, changed on falling link clock, msb first

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         tx       <= '0;
         tx_act   <= 1'b0;
         miso_out <= 1'b0;
      end else if (pins.cs_b) begin
         tx_act   <= 1'b0;
         miso_out <= 1'b0;
      end else if (rise && state == spp_pkg::ST_OPC && bit_cnt == `SPP_LEN_OPC - 1'b1) begin
         tx_act <= 1'b1;
         case (next_byte)
            `SPP_OP_RD_MODE: tx <= {mode_rd, {(`SPP_PWD_W-`SPP_MODE_W){1'b0}}};
            // password hidden for good once protection is on
            `SPP_OP_RD_PWD:  tx <= pwd_dis ? pwd : `SPP_PWD_BLANK;
            `SPP_OP_RD_FRZ:  tx <= {{(`SPP_FRZ_W-1){1'b0}}, freeze,
                                   {(`SPP_PWD_W-`SPP_FRZ_W){1'b0}}};
            default: begin
               tx     <= '0;
               tx_act <= 1'b0;
            end
         endcase
      end else if (rise && state == spp_pkg::ST_ARG && bit_cnt == `SPP_LEN_ADDR - 1'b1
                   && (opc == `SPP_OP_RD_NV || opc == `SPP_OP_RD_V)) begin
         tx_act <= 1'b1;
         tx     <= {{(`SPP_FRZ_W-1){1'b0}},
                    (opc == `SPP_OP_RD_NV) ? nv_lock[next_byte[`SPP_ADDR_W-1:`SPP_SEC_W]]
                                           : v_bit(next_byte),
                    {(`SPP_PWD_W-`SPP_FRZ_W){1'b0}}};
      end else if (fall && tx_act) begin
         miso_out <= tx[`SPP_PWD_W-1];
         tx       <= {tx[`SPP_PWD_W-2:0], 1'b0};
      end
   end

   assign miso_oe_out = tx_act & ~pins.cs_b;

   ////////////////////////////////////////////////////////////////////////////
   // nonvolatile mode, password and sector locks

   always_ff @(posedge clk_in) begin
      if (!factory_b_in) begin
         pwd_dis  <= 1'b1;
         prot_sel <= 1'b1;
         pwd      <= `SPP_PWD_BLANK;
         nv_lock  <= '1;
      end else begin
         // refuse any write leaving both mode bits at zero
         if (do_wr_mode && (next_pwd_dis || next_prot_sel)) begin
            pwd_dis  <= next_pwd_dis;
            prot_sel <= next_prot_sel;
         end
         if (do_wr_pwd && pwd_dis) begin
            pwd <= rx;
         end
         if (freeze) begin
            if (do_ers_nv) begin
               nv_lock <= '1;
            end else if (do_wr_nv) begin
               nv_lock[nv_sec] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // freeze bit

   always_ff @(posedge clk_in) begin
      if (!factory_b_in) begin
         freeze <= 1'b1;
      end else if (!rst_b_in) begin
         freeze <= pwd_dis;
      end else if (do_wr_frz) begin
         freeze <= 1'b0;
      end else if (do_unlock && !pwd_dis && pwd_match) begin
         freeze <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // volatile locks

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         v_lock      <= '0;
         v_sub_first <= '0;
         v_sub_last  <= '0;
      end else if (do_wr_v) begin
         if (wr_sec == `SPP_FIRST_SEC) begin
            v_sub_first[wr_sub] <= rx[`SPP_VDATA_BIT];
         end else if (wr_sec == `SPP_LAST_SEC) begin
            v_sub_last[wr_sub] <= rx[`SPP_VDATA_BIT];
         end else begin
            v_lock[wr_sec] <= rx[`SPP_VDATA_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // protection answer for the array

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         chk_block_out <= 1'b0;
         freeze_out    <= 1'b1;
         pwd_en_out    <= 1'b0;
      end else begin
         chk_block_out <= ~nv_lock[chk_addr_in[`SPP_ADDR_W-1:`SPP_SEC_W]]
                          | v_bit(chk_addr_in);
         freeze_out    <= freeze;
         pwd_en_out    <= ~pwd_dis;
      end
   end

endmodule
`default_nettype wire
